// file: rsc_pkg.sv
/*
 * Shared constants for the radio serial command port: opcodes, power
 * states, quick-status selectors and timing counts.
 * Assumes a 100 MHz system clock.
 */
package rsc_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // command opcodes
  localparam logic [7:0] OP_READ_CTS    = 8'h44;
  localparam logic [7:0] OP_START_RX    = 8'h32;
  localparam logic [7:0] OP_CHANGE_STATE = 8'h34;
  localparam logic [7:0] OP_FIFO_READ   = 8'h77;
  localparam logic [7:0] OP_SET_QS_CFG  = 8'h11;
  localparam logic [7:0] OP_QS_A        = 8'h50;
  localparam logic [7:0] OP_QS_B        = 8'h51;
  localparam logic [7:0] OP_QS_C        = 8'h53;
  localparam logic [7:0] OP_QS_D        = 8'h57;

  // command-ready values
  localparam logic [7:0] CTS_READY = 8'hff;
  localparam logic [7:0] CTS_BUSY  = 8'h00;

  // power state codes carried in command parameters
  localparam logic [3:0] PS_CODE_SLEEP  = 4'h1;
  localparam logic [3:0] PS_CODE_SPI    = 4'h2;
  localparam logic [3:0] PS_CODE_READY  = 4'h3;
  localparam logic [3:0] PS_CODE_TUNE   = 4'h6;
  localparam logic [3:0] PS_CODE_RX     = 4'h8;

  // quick-status source selectors
  localparam logic [1:0] QS_SRC_STATE = 2'h0;
  localparam logic [1:0] QS_SRC_FIFO  = 2'h1;
  localparam logic [1:0] QS_SRC_RXCNT = 2'h2;
  localparam logic [1:0] QS_SRC_ZERO  = 2'h3;
  localparam logic [7:0] QS_CFG_RESET = 8'he4;

  // timing, in their own units, then in cycles
  localparam int unsigned CMD_DONE_NS   = 20000;
  localparam int unsigned RX_FROM_SD_US = 15000;
  localparam int unsigned RX_FROM_RDY_US = 122;
  localparam int unsigned RX_FROM_TUNE_US = 74;
  localparam int unsigned CMD_DONE_CYC  = CMD_DONE_NS * CLK_MHZ / 1000;
  localparam int unsigned RX_SD_CYC     = RX_FROM_SD_US * CLK_MHZ;
  localparam int unsigned RX_RDY_CYC    = RX_FROM_RDY_US * CLK_MHZ;
  localparam int unsigned RX_TUNE_CYC   = RX_FROM_TUNE_US * CLK_MHZ;

  localparam int unsigned FIFO_DEPTH = 64;
  localparam int unsigned BUF_DEPTH  = 8;

  typedef enum logic [2:0] {
    RSC_SHUTDOWN, RSC_SLEEP, RSC_SPI_ACTIVE, RSC_READY, RSC_TUNE, RSC_RX
  } rsc_pstate_t;

  typedef enum logic [2:0] {
    RSC_IDLE, RSC_OPCODE, RSC_PARAM, RSC_CTS, RSC_DATA, RSC_QS
  } rsc_phase_t;

endpackage : rsc_pkg

// file: rsc_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module rsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      next_level;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_level  = level + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_level  = '0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
    end
  end

  always_ff @(posedge clock) begin
    if (push && !flush) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : rsc_fifo

// file: rsc_port.sv
/*
 * Serial command port of a receiver: shifts in opcode and parameters on
 * the host clock, answers command-ready polls, quick-status reads and
 * receive FIFO reads, and runs the power-state sequencer.
 * Assumes the host drives the serial clock, data in and select from
 * outside this clock domain; all are synchronised here.
 */
// Behaviour
// - first byte after select falls is opcode, then parameter bytes
// - read data follows only after command-ready reads FFh; here the bytes after the command-ready byte always read 00h
// - command-ready reads FFh about 20 us after a command
// - output changes on falling edges, host samples on rising edges
// - quick-status reads need no command-ready poll
// - four quick-status registers, sources chosen by configuration
// - opcodes 50h 51h 53h 57h read quick-status A B C D
// - burst: after 16 clocks, next register every 8 clocks, wrapping
// - quick-status values frozen while select stays low
// - state changes only by commands, except shutdown pin; code also wakes sleep on select fall and leaves receive on its timer
// - states: shutdown, sleep, serial-active, ready, tune, receive
// - sequencer reaches receive from any state directly
// - begin-receive names the state to return to afterwards
// - receive reached 15 ms, 122 us, 74 us after select rises
// - received data on a pin or read from a 64-byte FIFO; the buffer here holds 8 bytes
// - serial access in sleep moves device to serial-active
// - shutdown clears state and ignores the serial link
`timescale 1ns/1ps
module rsc_port
#(
  parameter int RX_SD_CYCLES   = rsc_pkg::RX_SD_CYC,
  parameter int RX_RDY_CYCLES  = rsc_pkg::RX_RDY_CYC,
  parameter int RX_TUNE_CYCLES = rsc_pkg::RX_TUNE_CYC,
  parameter int RX_LEN_CYCLES  = 20000
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // serial link from host
  input  wire logic       sclk,
  input  wire logic       sdi,
  input  wire logic       select_n,
  output logic            sdo,
  output logic            sdo_oe,
  // power control pin
  input  wire logic       shutdown_pin,
  // demodulated receive stream
  input  wire logic       rx_valid,
  output logic            rx_ready,
  input  wire logic [7:0] rx_data,
  output logic            rx_data_pin,
  // state view
  output rsc_pkg::rsc_pstate_t pstate
);
  import rsc_pkg::*;

  // synchronisers
  logic [1:0] sclk_s, sdi_s, sel_s, sd_s;
  logic       sclk_d, sel_d;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_s <= 2'h0;
      sdi_s  <= 2'h0;
      sel_s  <= 2'h3;
      sd_s   <= 2'h3;
      sclk_d <= 1'b0;
      sel_d  <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      sdi_s  <= {sdi_s[0], sdi};
      sel_s  <= {sel_s[0], select_n};
      sd_s   <= {sd_s[0], shutdown_pin};
      sclk_d <= sclk_s[1];
      sel_d  <= sel_s[1];
    end
  end

  logic sd_on, sel_low, sel_fall, sel_rise, sck_rise, sck_fall;
  assign sd_on    = sd_s[1];
  assign sel_low  = !sel_s[1] && !sd_on;
  assign sel_fall = sel_d && !sel_s[1];
  assign sel_rise = !sel_d && sel_s[1];
  assign sck_rise = sel_low && !sclk_d && sclk_s[1];
  assign sck_fall = sel_low && sclk_d && !sclk_s[1];

  // receive buffer between demodulator and serial reads
  logic       buf_valid, buf_ready;
  logic [7:0] buf_data;
  logic [3:0] buf_level;
  logic [6:0] fifo_cnt;
  logic       rx_on;
  logic       pop_byte;
  rsc_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
    .clock    (clock),
    .rstn     (rstn),
    .flush    (sd_on),
    .in_valid (rx_valid && rx_on),
    .in_ready (buf_ready),
    .in_data  (rx_data),
    .out_valid(buf_valid),
    .out_ready(pop_byte),
    .out_data (buf_data),
    .level    (buf_level)
  );
  assign rx_ready = buf_ready && rx_on;

  // serial engine state
  rsc_phase_t  phase, next_phase;
  logic [7:0]  shreg, next_shreg;
  logic [2:0]  bitc, next_bitc;
  logic [7:0]  opcode, next_opcode;
  logic [7:0]  param0, next_param0;
  logic [3:0]  pcnt, next_pcnt;
  logic [7:0]  txreg, next_txreg;
  logic [1:0]  qidx, next_qidx;
  logic [7:0]  qs_cfg, next_qs_cfg;
  logic [7:0]  qs_snap [4];
  logic        snap_now;
  logic        cmd_go, next_cmd_go;
  logic [14:0] busy_cnt, next_busy_cnt;
  logic        sdo_r, next_sdo_r;

  // source selection for each quick-status register
  function automatic logic [7:0] qs_src(input logic [1:0] s,
                                        input rsc_pstate_t p,
                                        input logic [6:0] n);
    case (s)
      QS_SRC_STATE: qs_src = {5'h0, p};
      QS_SRC_FIFO:  qs_src = {1'b0, n};
      QS_SRC_RXCNT: qs_src = {4'h0, buf_level};
      default:      qs_src = 8'h00;
    endcase
  endfunction

  // snapshot only while select is high
  assign snap_now = sel_s[1];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_qs
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          qs_snap[gi] <= 8'h00;
        end else if (snap_now) begin
          qs_snap[gi] <= qs_src(qs_cfg[2*gi +: 2], pstate, fifo_cnt);
        end
      end
    end
  endgenerate

  always_comb begin
    next_phase    = phase;
    next_shreg    = shreg;
    next_bitc     = bitc;
    next_opcode   = opcode;
    next_param0   = param0;
    next_pcnt     = pcnt;
    next_txreg    = txreg;
    next_qidx     = qidx;
    next_qs_cfg   = qs_cfg;
    next_cmd_go   = 1'b0;
    next_sdo_r    = sdo_r;
    next_busy_cnt = (busy_cnt != 15'h0) ? busy_cnt - 15'h1 : busy_cnt;
    pop_byte      = 1'b0;
    // decode restarts at each select fall
    if (sel_fall && !sd_on) begin
      next_phase = RSC_OPCODE;
      next_bitc  = 3'h0;
      next_pcnt  = 4'h0;
    end else if (!sel_low) begin
      if (sel_rise && phase == RSC_PARAM) begin
        next_cmd_go = 1'b1;
      end
      next_phase = RSC_IDLE;
      next_sdo_r = 1'b0;
    end else if (sck_rise) begin
      // msb-first shift of opcode and parameters
      next_shreg = {shreg[6:0], sdi_s[1]};
      next_bitc  = bitc + 3'h1;
      if (bitc == 3'h7) begin
        if (phase == RSC_OPCODE) begin
          next_opcode = {shreg[6:0], sdi_s[1]};
          case ({shreg[6:0], sdi_s[1]})
            OP_QS_A: begin next_phase = RSC_QS; next_qidx = 2'h0; end
            OP_QS_B: begin next_phase = RSC_QS; next_qidx = 2'h1; end
            OP_QS_C: begin next_phase = RSC_QS; next_qidx = 2'h2; end
            OP_QS_D: begin next_phase = RSC_QS; next_qidx = 2'h3; end
            OP_READ_CTS: next_phase = RSC_CTS;
            OP_FIFO_READ: next_phase = RSC_DATA;
            default: begin
              next_phase    = RSC_PARAM;
              next_busy_cnt = 15'(CMD_DONE_CYC);
            end
          endcase
          next_txreg = qs_snap[next_qidx];
          if (next_phase == RSC_CTS) begin
            // ready value only once the command finishes
            next_txreg = (busy_cnt == 15'h0) ? CTS_READY : CTS_BUSY;
          end else if (next_phase == RSC_DATA) begin
            next_txreg = buf_data;
            pop_byte   = buf_valid;
          end
        end else begin
          if (pcnt == 4'h0) begin
            next_param0 = {shreg[6:0], sdi_s[1]};
          end
          if (opcode == OP_SET_QS_CFG && pcnt == 4'h0) begin
            next_qs_cfg = {shreg[6:0], sdi_s[1]};
          end
          if (pcnt != 4'hf) begin
            next_pcnt = pcnt + 4'h1;
          end
          if (phase == RSC_QS) begin
            // burst wraps d back to a
            next_qidx  = qidx + 2'h1;
            next_txreg = qs_snap[qidx + 2'h1];
          end else if (phase == RSC_CTS) begin
            next_txreg = 8'h00;
          end else if (phase == RSC_DATA) begin
            next_txreg = buf_data;
            pop_byte   = buf_valid;
          end
        end
      end
    end else if (sck_fall) begin
      if (phase == RSC_QS || phase == RSC_CTS || phase == RSC_DATA) begin
        next_sdo_r = txreg[3'h7 - bitc];
      end
    end
  end

  // fifo byte count and pop from the buffer
  logic [6:0] next_fifo_cnt;
  always_comb begin
    next_fifo_cnt = fifo_cnt;
    if (pop_byte && fifo_cnt != 7'h0) begin
      next_fifo_cnt = fifo_cnt - 7'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase    <= RSC_IDLE;
      shreg    <= 8'h00;
      bitc     <= 3'h0;
      opcode   <= 8'h00;
      param0   <= 8'h00;
      pcnt     <= 4'h0;
      txreg    <= 8'h00;
      qidx     <= 2'h0;
      qs_cfg   <= QS_CFG_RESET;
      cmd_go   <= 1'b0;
      busy_cnt <= 15'h0;
      sdo_r    <= 1'b0;
    end else if (sd_on) begin
      phase    <= RSC_IDLE;
      shreg    <= 8'h00;
      bitc     <= 3'h0;
      opcode   <= 8'h00;
      param0   <= 8'h00;
      pcnt     <= 4'h0;
      txreg    <= 8'h00;
      qidx     <= 2'h0;
      qs_cfg   <= QS_CFG_RESET;
      cmd_go   <= 1'b0;
      busy_cnt <= 15'h0;
      sdo_r    <= 1'b0;
    end else begin
      phase    <= next_phase;
      shreg    <= next_shreg;
      bitc     <= next_bitc;
      opcode   <= next_opcode;
      param0   <= next_param0;
      pcnt     <= next_pcnt;
      txreg    <= next_txreg;
      qidx     <= next_qidx;
      qs_cfg   <= next_qs_cfg;
      cmd_go   <= next_cmd_go;
      busy_cnt <= next_busy_cnt;
      sdo_r    <= next_sdo_r;
    end
  end

  assign sdo    = sdo_r;
  assign sdo_oe = sel_low;

  // power-state sequencer
  rsc_pstate_t next_pstate, ret_state, next_ret_state;
  rsc_pstate_t tgt, next_tgt;
  logic [20:0] seq_cnt, next_seq_cnt;
  logic        was_sd;
  logic [6:0]  next_cnt_in;

  function automatic rsc_pstate_t code2st(input logic [3:0] c);
    case (c)
      PS_CODE_SLEEP: code2st = RSC_SLEEP;
      PS_CODE_READY: code2st = RSC_READY;
      PS_CODE_TUNE:  code2st = RSC_TUNE;
      PS_CODE_RX:    code2st = RSC_RX;
      default:       code2st = RSC_SPI_ACTIVE;
    endcase
  endfunction

  assign rx_on       = (pstate == RSC_RX);
  assign rx_data_pin = buf_valid && buf_data[0];

  always_comb begin
    next_pstate    = pstate;
    next_ret_state = ret_state;
    next_tgt       = tgt;
    next_seq_cnt   = (seq_cnt != 21'h0) ? seq_cnt - 21'h1 : seq_cnt;
    // serial access wakes sleep into serial-active
    if (pstate == RSC_SLEEP && sel_fall) begin
      next_pstate = RSC_SPI_ACTIVE;
    end
    if (cmd_go) begin
      if (opcode == OP_START_RX) begin
        // remember where to go after receive
        next_ret_state = code2st(param0[3:0]);
        next_tgt       = RSC_RX;
      end else if (opcode == OP_CHANGE_STATE) begin
        next_tgt = code2st(param0[3:0]);
      end
      if (opcode == OP_START_RX ||
          (opcode == OP_CHANGE_STATE && code2st(param0[3:0]) == RSC_RX)) begin
        if (was_sd) begin
          next_seq_cnt = 21'(RX_SD_CYCLES);
        end else if (pstate == RSC_TUNE) begin
          next_seq_cnt = 21'(RX_TUNE_CYCLES);
        end else begin
          next_seq_cnt = 21'(RX_RDY_CYCLES);
        end
      end else if (opcode == OP_CHANGE_STATE) begin
        next_pstate = code2st(param0[3:0]);
      end
    end else if (tgt == RSC_RX && seq_cnt == 21'h0 && pstate != RSC_RX) begin
      next_pstate  = RSC_RX;
      next_seq_cnt = 21'(RX_LEN_CYCLES);
    end else if (pstate == RSC_RX && seq_cnt == 21'h0 &&
                 ret_state != RSC_RX) begin
      // automatic return after the receive period
      next_pstate = ret_state;
      next_tgt    = ret_state;
    end
  end

  always_comb begin
    next_cnt_in = next_fifo_cnt;
    if (rx_valid && rx_ready && next_fifo_cnt != 7'(FIFO_DEPTH)) begin
      // byte count of the 8-byte receive buffer, capped at 64
      next_cnt_in = next_fifo_cnt + 7'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pstate    <= RSC_SHUTDOWN;
      ret_state <= RSC_RX;
      tgt       <= RSC_SPI_ACTIVE;
      seq_cnt   <= 21'h0;
      was_sd    <= 1'b1;
      fifo_cnt  <= 7'h0;
    end else if (sd_on) begin
      // shutdown held by the pin alone
      pstate    <= RSC_SHUTDOWN;
      ret_state <= RSC_RX;
      tgt       <= RSC_SPI_ACTIVE;
      seq_cnt   <= 21'h0;
      was_sd    <= 1'b1;
      fifo_cnt  <= 7'h0;
    end else begin
      pstate    <= (pstate == RSC_SHUTDOWN) ? RSC_SPI_ACTIVE : next_pstate;
      ret_state <= next_ret_state;
      tgt       <= next_tgt;
      seq_cnt   <= next_seq_cnt;
      was_sd    <= was_sd && !(pstate == RSC_RX);
      fifo_cnt  <= next_cnt_in;
    end
  end

endmodule : rsc_port

// file: rsc_port_properties.sv
/*
 * Checker for the serial command port, bound into rsc_port.
 * Assumes one clock domain with the asynchronous active-low reset.
 */
`timescale 1ns/1ps
module rsc_port_properties
  import rsc_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 rstn,
  input wire logic                 sclk,
  input wire logic                 select_n,
  input wire logic                 sdo,
  input wire logic                 sdo_oe,
  input wire logic                 shutdown_pin,
  input wire logic                 rx_ready,
  input wire rsc_pkg::rsc_pstate_t pstate
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_oe_idle_off: assert property (select_n [*4] |-> !sdo_oe)
    else $error("sdo enabled while deselected");
  a_sdo_idle_low: assert property (select_n [*5] |-> !sdo)
    else $error("sdo not low while deselected");
  a_sd_holds_state: assert property (
    shutdown_pin [*4] |-> pstate == RSC_SHUTDOWN)
    else $error("shutdown pin did not hold shutdown");
  a_sd_link_dead: assert property (shutdown_pin [*4] |-> !sdo_oe)
    else $error("serial output active in shutdown");
  a_sdo_on_fall: assert property (
    $changed(sdo) && sdo_oe && $past(sdo_oe) |-> !sclk && !$past(sclk, 2))
    else $error("sdo changed outside the low clock phase");
  a_rx_only_rx: assert property (
    rx_ready |-> pstate == RSC_RX || $past(pstate) == RSC_RX)
    else $error("stream accepted outside receive");
  a_wake_after_sd: assert property (
    $fell(shutdown_pin) ##1 !shutdown_pin [*6] |->
      pstate == RSC_SPI_ACTIVE)
    else $error("no serial-active state after shutdown");
  a_state_legal: assert property (
    pstate inside {RSC_SHUTDOWN, RSC_SLEEP, RSC_SPI_ACTIVE,
                   RSC_READY, RSC_TUNE, RSC_RX})
    else $error("illegal power state");

  c_rx_accept: cover property (rx_ready && pstate == RSC_RX);
  c_shutdown: cover property ($fell(shutdown_pin));
  c_read_out: cover property ($changed(sdo) && sdo_oe);
endmodule : rsc_port_properties

bind rsc_port rsc_port_properties chk (
  .clock(clock), .rstn(rstn), .sclk(sclk), .select_n(select_n),
  .sdo(sdo), .sdo_oe(sdo_oe), .shutdown_pin(shutdown_pin),
  .rx_ready(rx_ready), .pstate(pstate)
);

// file: rsc_host_model.sv
/*
 * Host model: serial bus master for the command port, mode 0, 125 ns.
 * Assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/1ps
module rsc_host_model (
  // serial link
  output logic       sclk,
  output logic       sdi,
  output logic       select_n,
  input  wire logic  sdo,
  // byte read back
  output logic [7:0] rd
);
  event done;

  initial begin
    sclk     = 1'b0;
    sdi      = 1'b0;
    select_n = 1'b1;
    rd       = 8'h00;
  end

  task automatic open_frame();
    select_n <= 1'b0;
    #100;
  endtask : open_frame

  task automatic close_frame();
    #100;
    select_n <= 1'b1;
    sdi      <= ~sdi;
    #300;
  endtask : close_frame

  task automatic xfer(input logic [7:0] tx, input logic chk);
    for (int i = 7; i >= 0; i--) begin
      sdi <= tx[i];
      #62.5;
      sclk  <= 1'b1;
      rd[i] = sdo;
      #62.5;
      sclk <= 1'b0;
    end
    if (chk)
      -> done;
  endtask : xfer

  task automatic poll();
    open_frame();
    xfer(rsc_pkg::OP_READ_CTS, 1'b0);
    xfer(8'hff, 1'b1);
    close_frame();
  endtask : poll
endmodule : rsc_host_model

// file: rsc_port_tb.sv
/*
 * Self-checking bench for rsc_port with host model and stream source.
 * Assumes shortened sequencer counts set below.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  checked++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module rsc_port_tb;
  import rsc_pkg::*;
  localparam int SEQ   = 50;
  localparam int RXLEN = 400;
  logic        clock;
  logic        rstn;
  logic        sclk;
  logic        sdi;
  logic        select_n;
  logic        sdo;
  logic        sdo_oe;
  logic        shutdown_pin;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  rx_data;
  logic        rx_data_pin;
  rsc_pstate_t pstate;
  logic [7:0]  exp_q[$];
  logic [7:0]  pushed[$];
  logic [7:0]  ops[4] = '{OP_QS_A, OP_QS_B, OP_QS_C, OP_QS_D};
  logic        acc;
  logic [7:0]  exp_b;
  int          mismatches = 0;
  int          checked = 0;

  rsc_port #(.RX_SD_CYCLES(SEQ), .RX_RDY_CYCLES(SEQ),
    .RX_TUNE_CYCLES(SEQ), .RX_LEN_CYCLES(RXLEN)) uut (
    .clock(clock), .rstn(rstn), .sclk(sclk), .sdi(sdi),
    .select_n(select_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .shutdown_pin(shutdown_pin), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_data_pin(rx_data_pin), .pstate(pstate));

  rsc_host_model host (.sclk(sclk), .sdi(sdi), .select_n(select_n),
    .sdo(sdo), .rd());

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // every checked byte the host reads back meets the oldest note
  always @(host.done) begin
    exp_b = exp_q.pop_front();
    `CHK("read byte", exp_b, host.rd)
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic frame(input logic [7:0] op, input int n,
                       input logic [7:0] prm, input logic [7:0] mask);
    host.open_frame();
    host.xfer(op, 1'b0);
    for (int i = 0; i < n; i++)
      host.xfer(prm, mask[i]);
    host.close_frame();
  endtask : frame

  task automatic wait_state(input rsc_pstate_t s, input int lim);
    for (int n = 0; n < lim && pstate !== s; n++)
      @(posedge clock);
  endtask : wait_state

  initial begin
    #400us;
    mismatches++;
    complete_run();
  end

  initial begin
    rstn         = 1'b0;
    shutdown_pin = 1'b0;
    rx_valid     = 1'b0;
    rx_data      = 8'h00;
    void'($urandom(24));
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK("pstate", RSC_SPI_ACTIVE, pstate)
    // all sources zero, each opcode bursts five bytes
    frame(OP_SET_QS_CFG, 1, 8'hff, 8'h00);
    foreach (ops[k]) begin
      repeat (5) exp_q.push_back(8'h00);
      frame(ops[k], 5, 8'h00, 8'h1f);
    end
    // default sources: D, then A (state) B C D after the wrap
    frame(OP_SET_QS_CFG, 1, QS_CFG_RESET, 8'h00);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'(RSC_SPI_ACTIVE));
    repeat (3) exp_q.push_back(8'h00);
    frame(OP_QS_D, 5, 8'h00, 8'h1f);
    frame(OP_CHANGE_STATE, 1, {4'h0, PS_CODE_READY}, 8'h00);
    exp_q.push_back(CTS_BUSY);
    host.poll();
    repeat (2200) @(posedge clock);
    exp_q.push_back(CTS_READY);
    host.poll();
    `CHK("pstate", RSC_READY, pstate)
    frame(OP_START_RX, 1, {4'h0, PS_CODE_SLEEP}, 8'h00);
    wait_state(RSC_RX, 300);
    `CHK("pstate", RSC_RX, pstate)
    rx_data  <= 8'($urandom);
    rx_valid <= 1'b1;
    repeat (40) begin
      @(negedge clock);
      acc = rx_ready;
      if (acc)
        pushed.push_back(rx_data);
      @(posedge clock);
      if (acc)
        rx_data <= 8'($urandom);
    end
    rx_valid <= 1'b0;
    `CHK("accepted", 32'(BUF_DEPTH), 32'(pushed.size()))
    `CHK("data pin", pushed[0][0], rx_data_pin)
    wait_state(RSC_SLEEP, 1000);
    `CHK("pstate", RSC_SLEEP, pstate)
    // snapshot taken in sleep stays frozen through the wake
    exp_q.push_back(8'(RSC_SLEEP));
    repeat (2) exp_q.push_back(8'(BUF_DEPTH));
    frame(OP_QS_A, 3, 8'h00, 8'h07);
    foreach (pushed[i])
      exp_q.push_back(pushed[i]);
    frame(OP_FIFO_READ, 8, 8'h00, 8'hff);
    `CHK("pstate", RSC_SPI_ACTIVE, pstate)
    shutdown_pin <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK("pstate", RSC_SHUTDOWN, pstate)
    frame(OP_QS_A, 1, 8'h00, 8'h00);
    `CHK("sdo_oe", 1'b0, sdo_oe)
    shutdown_pin <= 1'b0;
    repeat (10) @(posedge clock);
    `CHK("pstate", RSC_SPI_ACTIVE, pstate)
    `CHK("notes left", 32'd0, 32'(exp_q.size()))
    complete_run();
  end
endmodule : rsc_port_tb
